// ---- verilog/ctxo_params.svh ----
// constants for the transfer, exchange and condition code slice of the cpu core
// assumes one core clock; included by the package user files by bare name
// Behaviour
// - second index minus two loads stack pointer
// - second index and extension copy to first
// - second index and extension copy to third
// - third extension into low nibble, high cleared
// - third index minus two loads stack pointer
// - third index and extension copy to first
// - third index and extension copy to second
// - swap double accumulator with second index
// - swap double accumulator with third index
// - swap extra accumulator with first index
// - swap extra accumulator with second index
// - swap extra accumulator with third index
// - result mode updates flags, keeps extension field
// - stacked mode replaces all sixteen flag bits
// - extension mode updates only program extension
// - short indexed adds unsigned 8-bit offset
// - mid indexed adds signed 16-bit offset
// - long indexed adds signed 20-bit offset
// - word operand spans address and address plus one
`ifndef CTXO_PARAMS_SVH
`define CTXO_PARAMS_SVH
`define CTXO_OP_Y_S 16'h375e
`define CTXO_OP_Y_X 16'h274d
`define CTXO_OP_Y_Z 16'h276d
`define CTXO_OP_ZK_B 16'h37ae
`define CTXO_OP_Z_S 16'h376e
`define CTXO_OP_Z_X 16'h274e
`define CTXO_OP_Z_Y 16'h275e
`define CTXO_OP_D_Y 16'h37dc
`define CTXO_OP_D_Z 16'h37ec
`define CTXO_OP_E_X 16'h374c
`define CTXO_OP_E_Y 16'h375c
`define CTXO_OP_E_Z 16'h376c
`define CTXO_EXEC_CYCLES 2
`define CTXO_SP_ADJ 20'h00002
`define CTXO_WORD_STEP 20'h00001
`define CTXO_CC_TOP 15
`define CTXO_PK_MSB 3
`define CTXO_PK_LSB 0
`define CTXO_REG_D 4'h0
`define CTXO_REG_E 4'h1
`define CTXO_REG_IX 4'h2
`define CTXO_REG_IY 4'h3
`define CTXO_REG_IZ 4'h4
`define CTXO_REG_SP 4'h5
`define CTXO_REG_CCR 4'h6
`define CTXO_REG_EXT 4'h7
`define CTXO_REG_STAT 4'h8
`define CTXO_RST_WORD 16'h0000
`define CTXO_RST_EXT 4'h0
`endif

// ---- verilog/ctxo_pkg.sv ----
// types shared by the core slice and its address generator
// assumes nothing beyond the parameter header
package ctxo_pkg;
  typedef enum logic {st_idle, st_exec} ctxo_st_e;
  typedef enum logic [3:0] {
    op_none,
    copy_second_index_to_stack,
    copy_second_to_first_index,
    copy_second_to_third_index,
    copy_third_ext_to_byte,
    copy_third_index_to_stack,
    copy_third_to_first_index,
    copy_third_to_second_index,
    swap_double_acc_second_index,
    swap_double_acc_third_index,
    swap_extra_acc_first_index,
    swap_extra_acc_second_index,
    swap_extra_acc_third_index
  } ctxo_op_e;
  typedef enum logic [1:0] {short_indexed_mode, mid_indexed_mode, long_indexed_mode} ctxo_ea_e;
  typedef enum logic [1:0] {cc_result, cc_stacked, cc_pk_only} ctxo_cc_e;
  typedef enum logic [1:0] {idx_first, idx_second, idx_third} ctxo_idx_e;
endpackage : ctxo_pkg

// ---- verilog/ctxo_agen.sv ----
// indexed effective address generator, one cycle latency
// assumes base is the selected extension and index concatenated
`timescale 1ns/10ps
`include "ctxo_params.svh"

module ctxo_agen
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire ctxo_pkg::ctxo_ea_e mode_i,
  input wire logic [19:0] base_i,
  input wire logic [19:0] off_i,
  input wire logic word_i,
  output logic [19:0] ea_o,
  output logic [19:0] next_o,
  output logic valid_o,
  output logic word_o
);
  logic [19:0] next_ea;

  always_comb
  begin
    unique case (mode_i)
      ctxo_pkg::short_indexed_mode: next_ea = base_i + {12'h000, off_i[7:0]};
      ctxo_pkg::mid_indexed_mode: next_ea = base_i + {{4{off_i[15]}}, off_i[15:0]};
      default: next_ea = base_i + off_i;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ea_o <= 20'h00000;
      next_o <= 20'h00000;
      valid_o <= 1'b0;
      word_o <= 1'b0;
    end
    else
    begin
      valid_o <= req_i;
      if (req_i)
      begin
        ea_o <= next_ea;
        // second byte of a word operand, wraps within the 20-bit space
        next_o <= next_ea + `CTXO_WORD_STEP;
        word_o <= word_i;
      end
    end
  end
endmodule : ctxo_agen

// ---- verilog/ctxo_core.sv ----
// core slice: register transfers, exchanges, flag restore, indexed addressing
// assumes a fetch unit that offers opcodes only while busy_o is low
`timescale 1ns/10ps
`include "ctxo_params.svh"

module ctxo_core
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] opcode_i,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o,
  input wire logic cc_upd_i,
  input wire ctxo_pkg::ctxo_cc_e cc_mode_i,
  input wire logic [15:0] alu_ccr_i,
  input wire logic [15:0] stack_ccr_i,
  input wire logic ea_req_i,
  input wire ctxo_pkg::ctxo_ea_e ea_mode_i,
  input wire ctxo_pkg::ctxo_idx_e ea_idx_i,
  input wire logic [19:0] ea_off_i,
  input wire logic ea_word_i,
  output logic [19:0] ea_o,
  output logic [19:0] ea_next_o,
  output logic ea_valid_o,
  output logic ea_word_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic [15:0] ccr_o
);
  ctxo_pkg::ctxo_st_e state;
  ctxo_pkg::ctxo_op_e op;
  ctxo_pkg::ctxo_op_e dec;
  logic [1:0] cnt;
  logic [15:0] d, e, ix, iy, iz, sp, cond_code_reg;
  logic [3:0] xk, yk, zk, sk;
  logic [15:0] next_d, next_e, next_ix, next_iy, next_iz, next_sp;
  logic [3:0] next_xk, next_yk, next_zk, next_sk;
  logic [19:0] ea_base;
  logic [15:0] rd_val;
  logic take, commit, sw_wr;

  function automatic ctxo_pkg::ctxo_op_e decode(input logic [15:0] opc);
    case (opc)
      `CTXO_OP_Y_S: decode = ctxo_pkg::copy_second_index_to_stack;
      `CTXO_OP_Y_X: decode = ctxo_pkg::copy_second_to_first_index;
      `CTXO_OP_Y_Z: decode = ctxo_pkg::copy_second_to_third_index;
      `CTXO_OP_ZK_B: decode = ctxo_pkg::copy_third_ext_to_byte;
      `CTXO_OP_Z_S: decode = ctxo_pkg::copy_third_index_to_stack;
      `CTXO_OP_Z_X: decode = ctxo_pkg::copy_third_to_first_index;
      `CTXO_OP_Z_Y: decode = ctxo_pkg::copy_third_to_second_index;
      `CTXO_OP_D_Y: decode = ctxo_pkg::swap_double_acc_second_index;
      `CTXO_OP_D_Z: decode = ctxo_pkg::swap_double_acc_third_index;
      `CTXO_OP_E_X: decode = ctxo_pkg::swap_extra_acc_first_index;
      `CTXO_OP_E_Y: decode = ctxo_pkg::swap_extra_acc_second_index;
      `CTXO_OP_E_Z: decode = ctxo_pkg::swap_extra_acc_third_index;
      default: decode = ctxo_pkg::op_none;
    endcase
  endfunction : decode

  // stack pointer lands two below the source so the next push hits its word
  function automatic logic [19:0] sp_load(input logic [3:0] k, input logic [15:0] r);
    sp_load = {k, r} - `CTXO_SP_ADJ;
  endfunction : sp_load

  assign dec = decode(opcode_i);
  assign take = (state == ctxo_pkg::st_idle) && instr_valid_i;
  assign commit = (state == ctxo_pkg::st_exec) && (cnt == 2'h0);
  // software writes are refused mid-instruction so operands stay stable
  assign sw_wr = (state == ctxo_pkg::st_idle) && reg_wr_i;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= ctxo_pkg::st_idle;
      op <= ctxo_pkg::op_none;
      cnt <= 2'h0;
    end
    else
    begin
      unique case (state)
        ctxo_pkg::st_idle:
        begin
          if (take && dec != ctxo_pkg::op_none)
          begin
            state <= ctxo_pkg::st_exec;
            op <= dec;
            cnt <= 2'(`CTXO_EXEC_CYCLES - 2);
          end
        end
        ctxo_pkg::st_exec:
        begin
          if (cnt == 2'h0)
            state <= ctxo_pkg::st_idle;
          else
            cnt <= cnt - 2'h1;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
    end
    else
    begin
      busy_o <= (take && dec != ctxo_pkg::op_none) || (state == ctxo_pkg::st_exec && cnt != 2'h0);
      done_o <= commit;
      illegal_o <= take && dec == ctxo_pkg::op_none;
    end
  end

  always_comb
  begin
    next_d = d;
    next_e = e;
    next_ix = ix;
    next_iy = iy;
    next_iz = iz;
    next_sp = sp;
    next_xk = xk;
    next_yk = yk;
    next_zk = zk;
    next_sk = sk;
    if (commit)
    begin
      case (op)
        ctxo_pkg::copy_second_index_to_stack: {next_sk, next_sp} = sp_load(yk, iy);
        ctxo_pkg::copy_second_to_first_index: {next_xk, next_ix} = {yk, iy};
        ctxo_pkg::copy_second_to_third_index: {next_zk, next_iz} = {yk, iy};
        ctxo_pkg::copy_third_ext_to_byte: next_d[7:0] = {4'h0, zk};
        ctxo_pkg::copy_third_index_to_stack: {next_sk, next_sp} = sp_load(zk, iz);
        ctxo_pkg::copy_third_to_first_index: {next_xk, next_ix} = {zk, iz};
        ctxo_pkg::copy_third_to_second_index: {next_yk, next_iy} = {zk, iz};
        ctxo_pkg::swap_double_acc_second_index:
        begin
          next_d = iy;
          next_iy = d;
        end
        ctxo_pkg::swap_double_acc_third_index:
        begin
          next_d = iz;
          next_iz = d;
        end
        ctxo_pkg::swap_extra_acc_first_index:
        begin
          next_e = ix;
          next_ix = e;
        end
        ctxo_pkg::swap_extra_acc_second_index:
        begin
          next_e = iy;
          next_iy = e;
        end
        ctxo_pkg::swap_extra_acc_third_index:
        begin
          next_e = iz;
          next_iz = e;
        end
        default: ;
      endcase
    end
    else if (sw_wr)
    begin
      case (reg_addr_i)
        `CTXO_REG_D: next_d = reg_wdata_i;
        `CTXO_REG_E: next_e = reg_wdata_i;
        `CTXO_REG_IX: next_ix = reg_wdata_i;
        `CTXO_REG_IY: next_iy = reg_wdata_i;
        `CTXO_REG_IZ: next_iz = reg_wdata_i;
        `CTXO_REG_SP: next_sp = reg_wdata_i;
        `CTXO_REG_EXT: {next_sk, next_zk, next_yk, next_xk} = reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      d <= `CTXO_RST_WORD;
      e <= `CTXO_RST_WORD;
    end
    else
    begin
      d <= next_d;
      e <= next_e;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {ix, iy, iz} <= {3{`CTXO_RST_WORD}};
      {xk, yk, zk} <= {3{`CTXO_RST_EXT}};
    end
    else
    begin
      {ix, iy, iz} <= {next_ix, next_iy, next_iz};
      {xk, yk, zk} <= {next_xk, next_yk, next_zk};
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sp <= `CTXO_RST_WORD;
      sk <= `CTXO_RST_EXT;
    end
    else
    begin
      sp <= next_sp;
      sk <= next_sk;
    end
  end

  // flags move only on an update request (result, stacked or extension mode) or a software write, never on a
  // transfer or swap; an update beats a software write in the same cycle
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      cond_code_reg <= `CTXO_RST_WORD;
    else if (cc_upd_i)
    begin
      unique case (cc_mode_i)
        ctxo_pkg::cc_result:
          cond_code_reg[`CTXO_CC_TOP:`CTXO_PK_MSB+1] <= alu_ccr_i[`CTXO_CC_TOP:`CTXO_PK_MSB+1];
        ctxo_pkg::cc_stacked: cond_code_reg <= stack_ccr_i;
        default: cond_code_reg[`CTXO_PK_MSB:`CTXO_PK_LSB] <= stack_ccr_i[`CTXO_PK_MSB:`CTXO_PK_LSB];
      endcase
    end
    else if (sw_wr && reg_addr_i == `CTXO_REG_CCR)
      cond_code_reg <= reg_wdata_i;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      ccr_o <= `CTXO_RST_WORD;
    else
      ccr_o <= cond_code_reg;
  end

  always_comb
  begin
    case (reg_addr_i)
      `CTXO_REG_D: rd_val = d;
      `CTXO_REG_E: rd_val = e;
      `CTXO_REG_IX: rd_val = ix;
      `CTXO_REG_IY: rd_val = iy;
      `CTXO_REG_IZ: rd_val = iz;
      `CTXO_REG_SP: rd_val = sp;
      `CTXO_REG_CCR: rd_val = cond_code_reg;
      `CTXO_REG_EXT: rd_val = {sk, zk, yk, xk};
      `CTXO_REG_STAT: rd_val = {15'h0000, state == ctxo_pkg::st_exec};
      default: rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_o <= 16'h0000;
    else
      reg_rdata_o <= reg_rd_i ? rd_val : 16'h0000;
  end

  always_comb
  begin
    unique case (ea_idx_i)
      ctxo_pkg::idx_second: ea_base = {yk, iy};
      ctxo_pkg::idx_third: ea_base = {zk, iz};
      default: ea_base = {xk, ix};
    endcase
  end

  ctxo_agen u_agen
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .req_i(ea_req_i),
    .mode_i(ea_mode_i),
    .base_i(ea_base),
    .off_i(ea_off_i),
    .word_i(ea_word_i),
    .ea_o(ea_o),
    .next_o(ea_next_o),
    .valid_o(ea_valid_o),
    .word_o(ea_word_o)
  );

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  done_timing_a: assert property (take && dec != ctxo_pkg::op_none |=> !done_o ##1 done_o)
    else $error("done not two cycles after accept");
  stack_from_y_a: assert property (take && opcode_i == `CTXO_OP_Y_S && !reg_wr_i
    |=> ##1 {sk, sp} == $past({yk, iy}, 2) - `CTXO_SP_ADJ)
    else $error("stack load from second index wrong");
  copy_y_x_a: assert property (take && opcode_i == `CTXO_OP_Y_X && !reg_wr_i
    |=> ##1 {xk, ix} == $past({yk, iy}, 2))
    else $error("second to first copy wrong");
  ext_byte_a: assert property (take && opcode_i == `CTXO_OP_ZK_B && !reg_wr_i
    |=> ##1 d == {$past(d[15:8], 2), 4'h0, $past(zk, 2)})
    else $error("third extension to byte wrong");
  stack_from_z_a: assert property (take && opcode_i == `CTXO_OP_Z_S && !reg_wr_i
    |=> ##1 {sk, sp} == $past({zk, iz}, 2) - `CTXO_SP_ADJ)
    else $error("stack load from third index wrong");
  swap_d_y_a: assert property (take && opcode_i == `CTXO_OP_D_Y && !reg_wr_i
    |=> ##1 d == $past(iy, 2) && iy == $past(d, 2))
    else $error("double accumulator swap wrong");
  swap_e_z_a: assert property (take && opcode_i == `CTXO_OP_E_Z && !reg_wr_i
    |=> ##1 e == $past(iz, 2) && iz == $past(e, 2))
    else $error("extra accumulator swap wrong");
  cc_result_a: assert property (cc_upd_i && cc_mode_i == ctxo_pkg::cc_result
    |=> cond_code_reg == {$past(alu_ccr_i[15:4]), $past(cond_code_reg[3:0])})
    else $error("result flag update wrong");
  cc_stack_a: assert property (cc_upd_i && cc_mode_i == ctxo_pkg::cc_stacked
    |=> cond_code_reg == $past(stack_ccr_i))
    else $error("stacked flag restore wrong");
  cc_pk_a: assert property (cc_upd_i && cc_mode_i == ctxo_pkg::cc_pk_only
    |=> cond_code_reg == {$past(cond_code_reg[15:4]), $past(stack_ccr_i[3:0])})
    else $error("extension field restore wrong");
  flags_kept_a: assert property (take && !cc_upd_i && !reg_wr_i ##1 !cc_upd_i
    |=> cond_code_reg == $past(cond_code_reg, 2))
    else $error("transfer altered flags");
  ea_short_a: assert property (ea_req_i && ea_mode_i == ctxo_pkg::short_indexed_mode
    && ea_idx_i == ctxo_pkg::idx_first |=> ea_o == $past({xk, ix}) + $past(ea_off_i[7:0]))
    else $error("short indexed address wrong");
  ea_word_a: assert property (ea_req_i && ea_mode_i == ctxo_pkg::long_indexed_mode
    && ea_idx_i == ctxo_pkg::idx_second
    |=> ea_next_o == $past({yk, iy}) + $past(ea_off_i) + 20'h00001)
    else $error("word second byte address wrong");

  swap_seen_c: cover property (take && opcode_i == `CTXO_OP_E_X ##2 done_o);
  stack_seen_c: cover property (take && opcode_i == `CTXO_OP_Z_S ##1 !done_o ##1 done_o);
  back_back_c: cover property (done_o && take && dec != ctxo_pkg::op_none);
  restore_c: cover property (cc_upd_i && cc_mode_i == ctxo_pkg::cc_stacked && busy_o);
endmodule : ctxo_core

// ---- verification/tb.sv ----
// self-checking bench for the transfer, exchange and flag slice of the core
// assumes ctxo_core alone, driven from here; its assertions live in the design
`timescale 1ns/10ps
`include "ctxo_params.svh"

module tb;
  logic clock_i;
  logic rst_i;
  logic instr_valid_i;
  logic [15:0] opcode_i;
  logic busy_o;
  logic done_o;
  logic illegal_o;
  logic cc_upd_i;
  ctxo_pkg::ctxo_cc_e cc_mode_i;
  logic [15:0] alu_ccr_i;
  logic [15:0] stack_ccr_i;
  logic ea_req_i;
  ctxo_pkg::ctxo_ea_e ea_mode_i;
  ctxo_pkg::ctxo_idx_e ea_idx_i;
  logic [19:0] ea_off_i;
  logic ea_word_i;
  logic [19:0] ea_o;
  logic [19:0] ea_next_o;
  logic ea_valid_o;
  logic ea_word_o;
  logic [3:0] reg_addr_i;
  logic [15:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [15:0] reg_rdata_o;
  logic [15:0] ccr_o;
  int miscompares;
  int n_tests;
  int cycles;
  logic [31:0] seed;
  // model: d e ix iy iz sp ccr ext, ext = {sk, zk, yk, xk}
  logic [15:0] mr [0:7];
  logic [15:0] ops [0:11];

  ctxo_core ctxo_core_inst (.clock_i(clock_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .opcode_i(opcode_i), .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o),
    .cc_upd_i(cc_upd_i), .cc_mode_i(cc_mode_i), .alu_ccr_i(alu_ccr_i),
    .stack_ccr_i(stack_ccr_i), .ea_req_i(ea_req_i), .ea_mode_i(ea_mode_i),
    .ea_idx_i(ea_idx_i), .ea_off_i(ea_off_i), .ea_word_i(ea_word_i), .ea_o(ea_o),
    .ea_next_o(ea_next_o), .ea_valid_o(ea_valid_o), .ea_word_o(ea_word_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ccr_o(ccr_o));

  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic results;
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // a hang ends the run instead of stalling the whole regression
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      results();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // sixteen shifts per value so successive values are not plain shifts of each other
  task automatic rnd(output logic [15:0] v);
    for (int i = 0; i < 16; i++)
      seed = lfsr_next(seed);
    v = seed[15:0];
  endtask : rnd

  task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    @(posedge clock_i);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    check($sformatf("reg%0d", a), reg_rdata_o, exp);
    @(posedge clock_i);
  endtask : rd

  task automatic load_all;
    for (int j = 0; j < 8; j++)
      wr(j[3:0], mr[j]);
  endtask : load_all

  task automatic check_all;
    for (int j = 0; j < 8; j++)
      rd(j[3:0], mr[j]);
    check("ccr_o", ccr_o, mr[6]);
  endtask : check_all

  task automatic copy(input int s, input int d);
    mr[d] = mr[s];
    mr[7][4*(d-2)+:4] = mr[7][4*(s-2)+:4];
  endtask : copy

  // the borrow of the minus two runs into the stack extension
  task automatic to_stack(input int s);
    logic [19:0] t;
    t = {mr[7][4*(s-2)+:4], mr[s]} - 20'h00002;
    mr[5] = t[15:0];
    mr[7][15:12] = t[19:16];
  endtask : to_stack

  task automatic swap(input int a, input int b);
    logic [15:0] t;
    t = mr[a];
    mr[a] = mr[b];
    mr[b] = t;
  endtask : swap

  task automatic model(input logic [15:0] op);
    case (op)
      `CTXO_OP_Y_S: to_stack(3);
      `CTXO_OP_Y_X: copy(3, 2);
      `CTXO_OP_Y_Z: copy(3, 4);
      `CTXO_OP_ZK_B: mr[0][7:0] = {4'h0, mr[7][11:8]};
      `CTXO_OP_Z_S: to_stack(4);
      `CTXO_OP_Z_X: copy(4, 2);
      `CTXO_OP_Z_Y: copy(4, 3);
      `CTXO_OP_D_Y: swap(0, 3);
      `CTXO_OP_D_Z: swap(0, 4);
      `CTXO_OP_E_X: swap(1, 2);
      `CTXO_OP_E_Y: swap(1, 3);
      default: swap(1, 4);
    endcase
  endtask : model

  // a second offer and a stack write in the busy cycle must both be ignored
  task automatic exec(input logic [15:0] op);
    logic [15:0] v;
    rnd(v);
    instr_valid_i <= 1'b1;
    opcode_i <= op;
    @(posedge clock_i);
    opcode_i <= `CTXO_OP_ZK_B;
    reg_addr_i <= `CTXO_REG_SP;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    #1;
    check("busy", busy_o, 1'b1);
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    reg_wr_i <= 1'b0;
    #1;
    check("done", done_o, 1'b1);
    check("busy_end", busy_o, 1'b0);
    @(posedge clock_i);
    model(op);
  endtask : exec

  initial
  begin
    logic [15:0] a;
    logic [15:0] s;
    logic [19:0] off;
    logic [19:0] base;
    logic [19:0] exp;
    int k;
    ops = '{`CTXO_OP_Y_S, `CTXO_OP_Y_X, `CTXO_OP_Y_Z, `CTXO_OP_ZK_B, `CTXO_OP_Z_S,
      `CTXO_OP_Z_X, `CTXO_OP_Z_Y, `CTXO_OP_D_Y, `CTXO_OP_D_Z, `CTXO_OP_E_X,
      `CTXO_OP_E_Y, `CTXO_OP_E_Z};
    seed = 32'd32541;
    miscompares = 0;
    n_tests = 0;
    cycles = 0;
    rst_i = 1'b1;
    instr_valid_i = 1'b0;
    opcode_i = 16'h0000;
    cc_upd_i = 1'b0;
    cc_mode_i = ctxo_pkg::cc_result;
    alu_ccr_i = 16'h0000;
    stack_ccr_i = 16'h0000;
    ea_req_i = 1'b0;
    ea_mode_i = ctxo_pkg::short_indexed_mode;
    ea_idx_i = ctxo_pkg::idx_first;
    ea_off_i = 20'h00000;
    ea_word_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 16'h0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    for (int j = 0; j < 8; j++)
      mr[j] = 16'h0000;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    check_all();
    rd(`CTXO_REG_STAT, 16'h0000);
    wr(4'hc, 16'h5a5a);
    rd(4'hc, 16'h0000);
    // round zero starts from all zeros so the stack borrow wraps the extension
    for (int r = 0; r < 2; r++)
      for (int i = 0; i < 12; i++)
      begin
        for (int j = 0; j < 8; j++)
          if (r == 1)
            rnd(mr[j]);
        load_all();
        exec(ops[i]);
        check_all();
      end
    instr_valid_i <= 1'b1;
    opcode_i <= 16'hffff;
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    #1;
    check("illegal", illegal_o, 1'b1);
    check("busy_ill", busy_o, 1'b0);
    @(posedge clock_i);
    check_all();
    for (int m = 0; m < 4; m++)
    begin
      rnd(a);
      rnd(s);
      rnd(mr[6]);
      wr(`CTXO_REG_CCR, mr[6]);
      cc_upd_i <= 1'b1;
      cc_mode_i <= ctxo_pkg::ctxo_cc_e'(m[1:0]);
      alu_ccr_i <= a;
      stack_ccr_i <= s;
      @(posedge clock_i);
      cc_upd_i <= 1'b0;
      if (m == 0)
        mr[6][15:4] = a[15:4];
      else if (m == 1)
        mr[6] = s;
      else
        mr[6][3:0] = s[3:0];
      @(posedge clock_i);
      #1;
      check("ccr_o_upd", ccr_o, mr[6]);
      rd(`CTXO_REG_CCR, mr[6]);
    end
    for (int md = 0; md < 3; md++)
      for (int ix = 0; ix < 4; ix++)
      begin
        rnd(a);
        rnd(s);
        off = {s[3:0], a};
        k = (ix == 3) ? 0 : ix;
        base = {mr[7][4*k+:4], mr[2+k]};
        exp = (md == 0) ? base + {12'h000, off[7:0]} :
          (md == 1) ? base + {{4{off[15]}}, off[15:0]} : base + off;
        ea_req_i <= 1'b1;
        ea_mode_i <= ctxo_pkg::ctxo_ea_e'(md[1:0]);
        ea_idx_i <= ctxo_pkg::ctxo_idx_e'(ix[1:0]);
        ea_off_i <= off;
        ea_word_i <= s[4];
        @(posedge clock_i);
        ea_req_i <= 1'b0;
        #1;
        check("ea_valid", ea_valid_o, 1'b1);
        check("ea", ea_o, exp);
        check("ea_next", ea_next_o, exp + 20'h00001);
        check("ea_word", ea_word_o, s[4]);
        @(posedge clock_i);
      end
    results();
  end
endmodule : tb
